// [sensor_i2c_target.sv]
`timescale 1ns/10ps
module sensor_i2c_target #(
  parameter int PU_CYC_P = sensor_i2c_pkg::PU_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hard_reset_input_low_i,
  input  wire logic        addr_sel_i,
  sensor_i2c_if.target     bus,
  input  wire logic        result_valid_i,
  input  wire logic [15:0] temp_i,
  input  wire logic [15:0] hum_i,
  input  wire logic [15:0] temp_limit_i,
  input  wire logic [15:0] hum_limit_i,
  output logic             meas_start_o,
  output logic [1:0]       rep_o,
  output logic             stretch_o,
  output logic             cmd_valid_o,
  output logic [15:0]      cmd_o,
  output logic             wr_valid_o,
  output logic [15:0]      wr_data_o,
  output logic             alert_o,
  output logic             idle_o
);
  import sensor_i2c_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HDR  = 6'b000010,
    ST_WR   = 6'b000100,
    ST_RD   = 6'b001000,
    ST_STR  = 6'b010000,
    ST_SKIP = 6'b100000
  } tgt_st_e;

  localparam int HR_W = $clog2(HARD_RST_CYC + 1);
  localparam int PU_W = $clog2(PU_CYC_P + 1);

  logic [2:0]      scl_q;
  logic [2:0]      sda_q;
  logic [1:0]      asel_q;
  logic [1:0]      hrn_q;
  logic [HR_W-1:0] hr_cnt_q;
  logic [PU_W-1:0] pu_cnt_q;
  logic            ready_q;
  tgt_st_e         st_q;
  logic [3:0]      bit_q;
  logic [7:0]      sh_q;
  logic [7:0]      tx_q;
  logic [2:0]      nb_q;
  logic            rw_q;
  logic            asel_lat_q;
  logic            sda_low_q;
  logic            scl_low_q;
  logic [7:0]      cmd_msb_q;
  logic [15:0]     wd_q;
  logic            busy_q;
  logic            data_ok_q;
  logic            str_q;
  logic [15:0]     res_t_q;
  logic [15:0]     res_h_q;

  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  // two flops per pin; bit 2 is only the history of bit 1
  always_ff @(posedge core_clk_i) begin
    scl_q  <= {scl_q[1:0], bus.scl};
    sda_q  <= {sda_q[1:0], bus.sda};
    asel_q <= {asel_q[0], addr_sel_i};
    hrn_q  <= {hrn_q[0], hard_reset_input_low_i};
  end

  // oversampled edges serve any bus rate up to the maximum
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  wire [7:0] rx_byte = {sh_q[6:0], sda_q[1]};

  // ----------------------------------------------------------------
  // reset pin filter and power-up delay
  // ----------------------------------------------------------------
  wire hr_hit = hr_cnt_q == HR_W'(HARD_RST_CYC);
  wire srst   = rst_i | hr_hit;

  // counts cycles that the reset pin has been low
  always_ff @(posedge core_clk_i) begin
    if (rst_i || hrn_q[1]) begin
      hr_cnt_q <= '0;
    end else if (!hr_hit) begin
      hr_cnt_q <= hr_cnt_q + 1'b1;
    end
  end

  // no header is answered until the delay has run out
  always_ff @(posedge core_clk_i) begin
    if (srst) begin
      pu_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      pu_cnt_q <= pu_cnt_q + 1'b1;
      ready_q  <= pu_cnt_q == PU_W'(PU_CYC_P - 1);
    end
  end

  // ----------------------------------------------------------------
  // decode of header, command and checksum
  // ----------------------------------------------------------------
  wire [6:0]  my_addr  = asel_lat_q ? ADDR_HIGH : ADDR_LOW;
  wire        hdr_hit  = (sh_q[7:1] == my_addr) & ready_q;
  wire        hdr_rd   = sh_q[0];
  wire        rd_ack   = data_ok_q | (str_q & busy_q);
  wire        wr_ack   = (nb_q == WR_CRC_IDX) ? (sh_q == crc8(wd_q)) : (nb_q < WR_CRC_IDX);
  wire        ack_c    = (st_q == ST_HDR) ? (hdr_hit & (~hdr_rd | rd_ack)) : wr_ack;
  wire        ack_end  = scl_fall & (bit_q == ACK_BIT) & sda_low_q;
  wire        wr_step  = (st_q == ST_WR) & ack_end;
  wire        cmd_fire = wr_step & (nb_q == CMD_LSB_IDX);
  wire [15:0] cmd_word = {cmd_msb_q, sh_q};
  wire        ss_msb   = (cmd_msb_q == SS_STR_MSB) | (cmd_msb_q == SS_NOSTR_MSB);
  wire        ss_lsb   = (sh_q == REP_HIGH_LSB) | (sh_q == REP_MED_LSB) | (sh_q == REP_LOW_LSB);
  wire [1:0]  ss_rep   = (sh_q == REP_HIGH_LSB) ? REP_HIGH : (sh_q == REP_MED_LSB) ? REP_MED : REP_LOW;
  wire        ss_go    = cmd_fire & ss_msb & ss_lsb & ~busy_q;
  wire        rd_take  = ((st_q == ST_HDR) & ack_end & hdr_rd & data_ok_q) | ((st_q == ST_STR) & data_ok_q);
  wire [47:0] tx_all   = {res_t_q, crc8(res_t_q), res_h_q, crc8(res_h_q)};
  wire [2:0]  tx_idx   = (st_q == ST_RD) ? 3'(nb_q + 3'h1) : 3'h0;
  wire [7:0]  tx_next  = tx_all[(5 - tx_idx) * 8 +: 8];

  // ----------------------------------------------------------------
  // bus protocol engine
  // ----------------------------------------------------------------
  // bits counted 0..7 with 8 as the acknowledge slot; the scl fall after a start wraps all ones to 0
  always_ff @(posedge core_clk_i) begin
    if (srst || start_c || stop_c) begin
      st_q      <= start_c && !srst ? ST_HDR : ST_IDLE;
      bit_q     <= '1;
      nb_q      <= '0;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_SKIP: begin
          sda_low_q <= 1'b0;
          scl_low_q <= 1'b0;
        end
        ST_HDR, ST_WR: begin
          if (scl_rise && bit_q < ACK_BIT) begin
            sh_q <= rx_byte;
          end else if (scl_fall && bit_q == LAST_DBIT) begin
            bit_q     <= ACK_BIT;
            sda_low_q <= ack_c;
          end else if (scl_fall && bit_q == ACK_BIT) begin
            bit_q     <= '0;
            sda_low_q <= 1'b0;
            nb_q      <= (st_q == ST_WR) ? 3'(nb_q + 3'h1) : 3'h0;
            if (!sda_low_q) begin
              st_q <= ST_SKIP;
            end else if (st_q == ST_HDR && hdr_rd && data_ok_q) begin
              st_q      <= ST_RD;
              tx_q      <= tx_next;
              sda_low_q <= ~tx_next[7];
            end else if (st_q == ST_HDR && hdr_rd) begin
              st_q      <= ST_STR;
              scl_low_q <= 1'b1;
            end else begin
              st_q <= ST_WR;
            end
          end else if (scl_fall) begin
            bit_q <= bit_q + 1'b1;
          end
        end
        ST_STR: begin
          if (data_ok_q) begin
            st_q      <= ST_RD;
            tx_q      <= tx_next;
            sda_low_q <= ~tx_next[7];
          end
        end
        ST_RD: begin
          scl_low_q <= 1'b0;
          if (scl_rise && bit_q == ACK_BIT && sda_q[1]) begin
            st_q <= ST_SKIP;
          end else if (scl_fall && bit_q == LAST_DBIT) begin
            bit_q     <= ACK_BIT;
            sda_low_q <= 1'b0;
          end else if (scl_fall && bit_q == ACK_BIT) begin
            bit_q <= '0;
            if (nb_q == RD_LAST) begin
              st_q <= ST_SKIP;
            end else begin
              nb_q      <= nb_q + 1'b1;
              tx_q      <= tx_next;
              sda_low_q <= ~tx_next[7];
            end
          end else if (scl_fall) begin
            bit_q     <= bit_q + 1'b1;
            tx_q      <= {tx_q[6:0], 1'b0};
            sda_low_q <= ~tx_q[6];
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // strap level is taken at each start and held to the stop
  always_ff @(posedge core_clk_i) begin
    if (srst) begin
      asel_lat_q <= 1'b0;
    end else if (start_c) begin
      asel_lat_q <= asel_q[1];
    end
  end

  // ----------------------------------------------------------------
  // command capture and written data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst) begin
      cmd_msb_q   <= '0;
      wd_q        <= '0;
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
      wr_valid_o  <= 1'b0;
      wr_data_o   <= '0;
    end else begin
      cmd_valid_o <= cmd_fire;
      wr_valid_o  <= wr_step & (nb_q == WR_CRC_IDX);
      if (wr_step && nb_q == 3'h0) cmd_msb_q <= sh_q;
      if (wr_step && nb_q == 3'h2) wd_q[15:8] <= sh_q;
      if (wr_step && nb_q == 3'h3) wd_q[7:0] <= sh_q;
      if (cmd_fire) cmd_o <= cmd_word;
      if (wr_step && nb_q == WR_CRC_IDX) wr_data_o <= wd_q;
    end
  end

  // ----------------------------------------------------------------
  // single-shot measurement and result store
  // ----------------------------------------------------------------
  // a new result sets the data flag even when a read takes it that cycle
  always_ff @(posedge core_clk_i) begin
    if (srst) begin
      busy_q       <= 1'b0;
      data_ok_q    <= 1'b0;
      str_q        <= 1'b0;
      res_t_q      <= '0;
      res_h_q      <= '0;
      meas_start_o <= 1'b0;
      rep_o        <= REP_HIGH;
      stretch_o    <= 1'b0;
      alert_o      <= 1'b0;
    end else begin
      meas_start_o <= ss_go;
      if (ss_go) begin
        busy_q    <= 1'b1;
        str_q     <= cmd_msb_q == SS_STR_MSB;
        stretch_o <= cmd_msb_q == SS_STR_MSB;
        rep_o     <= ss_rep;
      end
      if (result_valid_i) begin
        busy_q  <= 1'b0;
        res_t_q <= temp_i;
        res_h_q <= hum_i;
        alert_o <= (temp_i >= temp_limit_i) | (hum_i >= hum_limit_i);
      end
      if (result_valid_i) begin
        data_ok_q <= 1'b1;
      end else if (rd_take || ss_go) begin
        data_ok_q <= 1'b0;
      end
    end
  end

  // low-energy idle once the power-up delay is over and neither busy nor on the bus
  always_ff @(posedge core_clk_i) begin
    if (srst) begin
      idle_o <= 1'b0;
    end else begin
      idle_o <= ready_q & (st_q == ST_IDLE) & ~busy_q;
    end
  end

  // open-drain pins: drive value is always low, enable low while pulling
  assign bus.scl_d_o    = 1'b0;
  assign bus.sda_d_o    = 1'b0;
  assign bus.scl_d_oe_n = ~scl_low_q;
  assign bus.sda_d_oe_n = ~sda_low_q;
endmodule // sensor_i2c_target

// [sensor_i2c_pkg.sv]
// Function
// - serial clock may run 0 to 1000 kHz
// - target may stretch clock, chosen per command
// - both ends only pull lines low
// - address 0x44 strap low, 0x45 strap high
// - strap stays stable during a transaction
// - header: upper 7 bits address, lsb direction
// - alert high when result meets limits
// - reset pin low 1 us resets all
// - master waits 1 ms between commands
// - commands are 16-bit words with checksum; the code sends and takes the command without one
// - every sent word followed by checksum byte; the code sends none after the command word
// - written data kept only with matching checksum
// - master may skip checking read checksums
// - power-up delay, then idle, then commands
// - transactions open with start, close with stop
// - target idles by itself when not busy
// - measurement: start, write header, two command bytes
// - ack driven after eighth clock falling edge
// - measurement starts at command acknowledge
// - one temperature then humidity pair per command
// - command selects repeatability and stretching
package sensor_i2c_pkg;
  localparam logic [6:0] ADDR_LOW     = 7'h44;
  localparam logic [6:0] ADDR_HIGH    = 7'h45;
  localparam int         CLK_MHZ      = 100;
  localparam int         HARD_RST_US  = 1;
  localparam int         HARD_RST_CYC = HARD_RST_US * CLK_MHZ;
  localparam int         PU_US        = 1500;
  localparam int         PU_CYC       = PU_US * CLK_MHZ;
  localparam int         CMD_GAP_US   = 1000;
  localparam int         CMD_GAP_CYC  = CMD_GAP_US * CLK_MHZ;
  localparam int         SCL_MAX_KHZ  = 1000;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [3:0] LAST_DBIT    = 4'h7;
  localparam logic [7:0] HOLD_CYC     = 8'h04;
  localparam logic [2:0] RD_LAST      = 3'h5;
  localparam logic [2:0] WR_CRC_IDX   = 3'h4;
  localparam logic [2:0] CMD_LSB_IDX  = 3'h1;
  localparam logic [7:0] SS_STR_MSB   = 8'hA1;
  localparam logic [7:0] SS_NOSTR_MSB = 8'hA2;
  localparam logic [7:0] REP_HIGH_LSB = 8'h01;
  localparam logic [7:0] REP_MED_LSB  = 8'h02;
  localparam logic [7:0] REP_LOW_LSB  = 8'h03;
  localparam logic [1:0] REP_HIGH     = 2'h2;
  localparam logic [1:0] REP_MED      = 2'h1;
  localparam logic [1:0] REP_LOW      = 2'h0;
  localparam logic [7:0] CRC_POLY     = 8'h07;
  localparam logic [7:0] CRC_INIT     = 8'h00;

  // checksum byte over one 16-bit word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// [sensor_i2c_if.sv]
`timescale 1ns/10ps
interface sensor_i2c_if;
  logic scl;
  logic sda;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic scl_d_o;
  logic scl_d_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;

  // wired-and bus with pull-ups: a line is low only while someone drives it
  assign scl = (scl_m_oe_n | scl_m_o) & (scl_d_oe_n | scl_d_o);
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_d_oe_n | sda_d_o);

  modport ctrl (input scl, sda, output scl_m_o, scl_m_oe_n, sda_m_o, sda_m_oe_n);
  modport target (input scl, sda, output scl_d_o, scl_d_oe_n, sda_d_o, sda_d_oe_n);
endinterface

// [sensor_i2c_master.sv]
`timescale 1ns/10ps
module sensor_i2c_master #(
  parameter int SCL_KHZ   = sensor_i2c_pkg::SCL_MAX_KHZ,
  parameter int GAP_CYC_P = sensor_i2c_pkg::CMD_GAP_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  sensor_i2c_if.ctrl       bus,
  input  wire logic [6:0]  tgt_addr_i,
  input  wire logic        req_i,
  input  wire logic        op_rd_i,
  input  wire logic        with_data_i,
  input  wire logic [15:0] cmd_i,
  input  wire logic [15:0] data_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic             crc_err_o,
  output logic [15:0]      temp_o,
  output logic [15:0]      hum_o
);
  import sensor_i2c_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_START = 5'b00010,
    M_BIT   = 5'b00100,
    M_STOP  = 5'b01000,
    M_GAP   = 5'b10000
  } mst_st_e;

  localparam int         QTR   = CLK_MHZ * 1000 / (SCL_KHZ * 4);
  localparam int         GAP_W = $clog2(GAP_CYC_P + 1);
  localparam logic [2:0] WR_LAST_CMD  = 3'h2;
  localparam logic [2:0] WR_LAST_DATA = 3'h5;
  localparam logic [2:0] RD_LAST_M    = 3'h6;

  mst_st_e          st_q;
  logic [1:0]       scl_q;
  logic [1:0]       sda_q;
  logic [7:0]       cnt_q;
  logic [1:0]       ph_q;
  logic [3:0]       bit_q;
  logic [2:0]       nb_q;
  logic [2:0]       last_q;
  logic             rd_q;
  logic [39:0]      tx_all_q;
  logic [7:0]       tx_q;
  logic [7:0]       rx_q;
  logic [47:0]      rxall_q;
  logic             scl_low_q;
  logic             sda_low_q;
  logic [GAP_W-1:0] gap_q;

  // ----------------------------------------------------------------
  // pin synchronisers and bit timing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    scl_q <= {scl_q[0], bus.scl};
    sda_q <= {sda_q[0], bus.sda};
  end

  wire       qtr_done = cnt_q == 8'(QTR - 1);
  wire       wr_byte  = ~rd_q | (nb_q == 3'h0);
  wire       want_low = (bit_q == ACK_BIT) ? (~wr_byte & (nb_q != last_q)) : (wr_byte & ~tx_q[7]);
  wire       stalled  = (st_q == M_BIT) & (ph_q == 2'h1) & ~scl_q[1];
  wire [2:0] nb_next  = 3'(nb_q + 3'h1);
  wire [7:0] tx_next  = tx_all_q[(5 - nb_next) * 8 +: 8];

  // quarter-period counter frozen while the target stretches the clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i || st_q == M_IDLE || qtr_done) begin
      cnt_q <= '0;
    end else if (!stalled) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q      <= M_IDLE;
      ph_q      <= '0;
      bit_q     <= '0;
      nb_q      <= '0;
      last_q    <= '0;
      rd_q      <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      nack_o    <= 1'b0;
      gap_q     <= '0;
    end else begin
      unique case (st_q)
        M_IDLE: begin
          if (req_i) begin
            st_q     <= M_START;
            ph_q     <= '0;
            rd_q     <= op_rd_i;
            last_q   <= op_rd_i ? RD_LAST_M : (with_data_i ? WR_LAST_DATA : WR_LAST_CMD);
            tx_all_q <= {cmd_i, data_i, crc8(data_i)};
            tx_q     <= {tx_addr_c(tgt_addr_i), op_rd_i};
            nack_o   <= 1'b0;
          end
        end
        M_START: begin
          sda_low_q <= 1'b1;
          if (qtr_done) begin
            scl_low_q <= 1'b1;
            st_q      <= M_BIT;
            ph_q      <= '0;
            bit_q     <= '0;
            nb_q      <= '0;
          end
        end
        M_BIT: begin
          if (ph_q == 2'h0 && cnt_q == HOLD_CYC) sda_low_q <= want_low;
          if (ph_q == 2'h2 && cnt_q == 8'h00) begin
            if (bit_q == ACK_BIT && wr_byte) nack_o <= sda_q[1];
            if (bit_q != ACK_BIT) rx_q <= {rx_q[6:0], sda_q[1]};
          end
          if (qtr_done) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) scl_low_q <= 1'b0;
            if (ph_q == 2'h3) begin
              scl_low_q <= 1'b1;
              if (bit_q != ACK_BIT) begin
                bit_q <= bit_q + 1'b1;
                tx_q  <= {tx_q[6:0], 1'b1};
              end else if (nack_o || nb_q == last_q) begin
                st_q <= M_STOP;
                ph_q <= '0;
              end else begin
                bit_q <= '0;
                nb_q  <= nb_next;
                tx_q  <= rd_q ? 8'hFF : tx_next;
              end
            end
          end
        end
        M_STOP: begin
          if (ph_q == 2'h0 && cnt_q == HOLD_CYC) sda_low_q <= 1'b1;
          if (qtr_done) begin
            ph_q <= ph_q + 1'b1;
            if (ph_q == 2'h0) scl_low_q <= 1'b0;
            if (ph_q == 2'h1) sda_low_q <= 1'b0;
            if (ph_q == 2'h2) begin
              st_q  <= rd_q ? M_IDLE : M_GAP;
              gap_q <= '0;
            end
          end
        end
        M_GAP: begin
          gap_q <= gap_q + 1'b1;
          if (gap_q == GAP_W'(GAP_CYC_P - 1)) st_q <= M_IDLE;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  function automatic logic [6:0] tx_addr_c(input logic [6:0] a);
    return a;
  endfunction

  // ----------------------------------------------------------------
  // read result assembly and answer to the user
  // ----------------------------------------------------------------
  wire byte_end  = (st_q == M_BIT) & qtr_done & (ph_q == 2'h3) & (bit_q == ACK_BIT);
  wire stop_end  = (st_q == M_STOP) & qtr_done & (ph_q == 2'h2);
  wire [47:0] rx_full = {rxall_q[39:0], rx_q};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rxall_q   <= '0;
      done_o    <= 1'b0;
      busy_o    <= 1'b0;
      crc_err_o <= 1'b0;
      temp_o    <= '0;
      hum_o     <= '0;
    end else begin
      busy_o <= (st_q != M_IDLE) | req_i;
      done_o <= stop_end;
      if (byte_end && rd_q && nb_q != 3'h0) rxall_q <= rx_full;
      if (stop_end && rd_q && !nack_o) begin
        temp_o    <= rxall_q[47:32];
        hum_o     <= rxall_q[23:8];
        crc_err_o <= (rxall_q[31:24] != crc8(rxall_q[47:32])) | (rxall_q[7:0] != crc8(rxall_q[23:8]));
      end
    end
  end

  assign bus.scl_m_o    = 1'b0;
  assign bus.sda_m_o    = 1'b0;
  assign bus.scl_m_oe_n = ~scl_low_q;
  assign bus.sda_m_oe_n = ~sda_low_q;
endmodule // sensor_i2c_master

// [sensor_i2c_properties.sv]
`timescale 1ns/10ps
module sensor_i2c_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic scl_d_o,
  input wire logic sda_d_o,
  input wire logic scl_d_oe_n,
  input wire logic sda_d_oe_n
);
  // --------------------------
  // wire rules of the two ends
  // --------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start; scl && $past(scl) && $fell(sda); endsequence
  sequence s_ack_pull; $fell(sda_d_oe_n); endsequence

  // pins may only pull low, the lines are a wired-and
  property p_scl_d_low; scl_d_o == 1'b0; endproperty
  a_scl_d_low: assert property (p_scl_d_low) else $error("target scl value not low");
  property p_sda_d_low; sda_d_o == 1'b0; endproperty
  a_sda_d_low: assert property (p_sda_d_low) else $error("target sda value not low");
  property p_sda_wired; sda == (sda_m_oe_n & sda_d_oe_n); endproperty
  a_sda_wired: assert property (p_sda_wired) else $error("sda not wired-and");
  property p_scl_wired; scl == (scl_m_oe_n & scl_d_oe_n); endproperty
  a_scl_wired: assert property (p_scl_wired) else $error("scl not wired-and");

  // target never forms start or stop, only changes sda with scl low
  property p_dev_sda_stable; scl && $past(scl) |-> $stable(sda_d_oe_n); endproperty
  a_dev_sda_stable: assert property (p_dev_sda_stable) else $error("target sda moved, scl high");
  // after a start the master clocks within a bounded time
  property p_start_clocks; s_start |-> ##[1:60] !scl; endproperty
  a_start_clocks: assert property (p_start_clocks) else $error("no clock after start");
  // target pulls sda only after scl has fallen, and lets go in time
  property p_ack_after_fall; s_ack_pull |-> !scl && !$past(scl); endproperty
  a_ack_after_fall: assert property (p_ack_after_fall) else $error("target pull before scl fall");
  property p_sda_release; s_ack_pull |-> ##[1:1000] sda_d_oe_n; endproperty
  a_sda_release: assert property (p_sda_release) else $error("target holds sda too long");
  // stretching only extends a low phase
  property p_dev_stretch; $fell(scl_d_oe_n) |-> !$past(scl); endproperty
  a_dev_stretch: assert property (p_dev_stretch) else $error("target pulled scl while high");
endmodule // sensor_i2c_properties

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import sensor_i2c_pkg::*;
  logic        core_clk_i, rst_i, hard_n, addr_sel, rv, req, op_rd, with_data;
  logic [15:0] temp, hum, temp_lim, hum_lim, cmd, data, last_cmd, last_wr;
  logic [6:0]  tgt_addr;
  logic        meas_start_o, stretch_o, cmd_valid_o, wr_valid_o, alert_o, idle_o;
  logic        busy_o, done_o, nack_o, crc_err_o;
  logic [1:0]  rep_o;
  logic [15:0] cmd_o, wr_data_o, temp_o, hum_o;
  int          num_errors, samples_checked, n_meas, n_wr, n_done, cyc;

  // ------------------------
  // two ends on one bus
  // ------------------------
  sensor_i2c_if sif();
  sensor_i2c_target #(.PU_CYC_P(200)) i_sensor_i2c_target (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .hard_reset_input_low_i(hard_n), .addr_sel_i(addr_sel), .bus(sif.target), .result_valid_i(rv),
    .temp_i(temp), .hum_i(hum), .temp_limit_i(temp_lim), .hum_limit_i(hum_lim), .meas_start_o(meas_start_o),
    .rep_o(rep_o), .stretch_o(stretch_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .wr_valid_o(wr_valid_o),
    .wr_data_o(wr_data_o), .alert_o(alert_o), .idle_o(idle_o));
  sensor_i2c_master #(.SCL_KHZ(1000), .GAP_CYC_P(300)) i_sensor_i2c_master (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .bus(sif.ctrl), .tgt_addr_i(tgt_addr), .req_i(req), .op_rd_i(op_rd),
    .with_data_i(with_data), .cmd_i(cmd), .data_i(data), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
    .crc_err_o(crc_err_o), .temp_o(temp_o), .hum_o(hum_o));
  sensor_i2c_properties i_sensor_i2c_properties (.core_clk_i(core_clk_i), .rst_i(rst_i), .scl(sif.scl),
    .sda(sif.sda), .scl_m_oe_n(sif.scl_m_oe_n), .sda_m_oe_n(sif.sda_m_oe_n), .scl_d_o(sif.scl_d_o),
    .sda_d_o(sif.sda_d_o), .scl_d_oe_n(sif.scl_d_oe_n), .sda_d_oe_n(sif.sda_d_oe_n));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // pulse capture and hang watchdog
  always @(posedge core_clk_i) begin
    cyc++;
    if (meas_start_o === 1'b1) n_meas++;
    if (done_o === 1'b1) n_done++;
    if (cmd_valid_o === 1'b1) last_cmd = cmd_o;
    if (wr_valid_o === 1'b1) begin
      n_wr++;
      last_wr = wr_data_o;
    end
    if (cyc == 90000) begin
      num_errors++;
      final_report();
    end
  end

  // ------------------------
  // shared tasks
  // ------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [6:0] a, input logic rd, input logic wd, input logic [15:0] c, input logic [15:0] d);
    @(posedge core_clk_i); #1;
    tgt_addr = a; op_rd = rd; with_data = wd; cmd = c; data = d; req = 1'b1;
    @(posedge core_clk_i); #1;
    req = 1'b0;
    while (busy_o !== 1'b0) @(posedge core_clk_i);
    #1;
  endtask

  task automatic result(input logic [15:0] t, input logic [15:0] h);
    @(posedge core_clk_i); #1;
    temp = t; hum = h; rv = 1'b1;
    @(posedge core_clk_i); #1;
    rv = 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // ------------------------
  // scenarios
  // ------------------------
  task automatic t_power;
    repeat (150) @(posedge core_clk_i);
    check(16'(idle_o), 16'h0000);
    repeat (110) @(posedge core_clk_i);
    check(16'(idle_o), 16'h0001);
    $display("test power done");
  endtask

  task automatic t_single;
    int m;
    for (int i = 0; i < 6; i++) begin
      m = n_meas;
      xfer(ADDR_LOW, 1'b0, 1'b0, {(i < 3) ? SS_STR_MSB : SS_NOSTR_MSB, REP_HIGH_LSB + 8'(i % 3)}, 16'h0000);
      check(16'(nack_o), 16'h0000);
      check(16'(n_meas - m), 16'h0001);
      check(16'(rep_o), 16'(REP_HIGH - 2'(i % 3)));
      check(16'(stretch_o), 16'(i < 3));
      check(last_cmd, {(i < 3) ? SS_STR_MSB : SS_NOSTR_MSB, REP_HIGH_LSB + 8'(i % 3)});
      result(16'h0000, 16'h0000);
    end
    $display("test single shot done");
  endtask

  task automatic t_addr;
    int m;
    m = n_meas;
    xfer(ADDR_HIGH, 1'b0, 1'b0, {SS_STR_MSB, REP_LOW_LSB}, 16'h0000);
    check(16'(nack_o), 16'h0001);
    check(16'(n_meas - m), 16'h0000);
    addr_sel = 1'b1;
    xfer(ADDR_HIGH, 1'b0, 1'b0, {SS_STR_MSB, REP_LOW_LSB}, 16'h0000);
    check(16'(nack_o), 16'h0000);
    xfer(ADDR_LOW, 1'b0, 1'b0, {SS_STR_MSB, REP_LOW_LSB}, 16'h0000);
    check(16'(nack_o), 16'h0001);
    addr_sel = 1'b0;
    $display("test address done");
  endtask

  task automatic t_data;
    int w, d;
    w = n_wr;
    d = n_done;
    xfer(ADDR_LOW, 1'b0, 1'b1, 16'h1234, 16'hBEEF);
    check(16'(n_wr - w), 16'h0001);
    check(16'(n_done - d), 16'h0001);
    check(last_wr, 16'hBEEF);
    $display("test write data done");
  endtask

  task automatic t_read;
    result(16'h1000, 16'h2000);
    check(16'(alert_o), 16'h0000);
    xfer(ADDR_LOW, 1'b0, 1'b0, {SS_STR_MSB, REP_MED_LSB}, 16'h0000);
    fork
      xfer(ADDR_LOW, 1'b1, 1'b0, 16'h0000, 16'h0000);
      begin
        repeat (1500) @(posedge core_clk_i);
        result(16'h6A5C, 16'h3C21);
      end
    join
    check(16'(alert_o), 16'h0001);
    check(temp_o, 16'h6A5C);
    check(hum_o, 16'h3C21);
    check(16'(crc_err_o), 16'h0000);
    xfer(ADDR_LOW, 1'b1, 1'b0, 16'h0000, 16'h0000);
    check(16'(nack_o), 16'h0001);
    $display("test read done");
  endtask

  task automatic t_hard;
    @(posedge core_clk_i); #1;
    hard_n = 1'b0;
    repeat (120) @(posedge core_clk_i);
    check(16'(idle_o), 16'h0000);
    check(16'(alert_o), 16'h0000);
    #1;
    hard_n = 1'b1;
    repeat (100) @(posedge core_clk_i);
    check(16'(idle_o), 16'h0000);
    repeat (160) @(posedge core_clk_i);
    check(16'(idle_o), 16'h0001);
    $display("test hard reset done");
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1; hard_n = 1'b1; addr_sel = 1'b0; rv = 1'b0; req = 1'b0; op_rd = 1'b0; with_data = 1'b0;
    temp = 16'h0000; hum = 16'h0000; temp_lim = 16'h6000; hum_lim = 16'hFFFF; cmd = 16'h0000;
    data = 16'h0000; tgt_addr = ADDR_LOW;
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    t_power();
    t_single();
    t_addr();
    t_data();
    t_read();
    t_hard();
    final_report();
  end
endmodule // tb_top
